// file: rtl/scsd_top.sv
/*
 * System clock select and divide block with APB register access.
 * Picks the main or ring oscillator, divides by 1, 2, 4 or 8 and
 * derives the instruction clock by three.
 * Assumes both oscillator inputs are slower than pclk / 4 and come
 * from outside the pclk domain.
 */
// How it works
// RL1: bit 0 picks main or ring source
// RL2: bits 3:2 pick divide 1, 2, 4, 8
// RL3: ring source ignores bit 1, same ratios
// RL4: main modes only when bits 1:0 zero
// RL5: instruction clock is system clock over three
// RL6: one instruction clock period per machine cycle
// RL7: reset selects ring oscillator divided by eight
// RL8: software starts ring oscillator before selecting; the block has no ring enable and uses it from reset
// RL9: main input any oscillator type, ring internal
// RL10: clearing bit 1 starts main oscillator
// RL11: software enables main before switching to it
// RL12: mode changes only at period boundaries, glitch free; stopping applied main ends the period at once and can cut a high pulse short
// RL13: instruction divider restarts at known phase
`timescale 1ns/100ps
module scsd_top #(
    parameter int CYCLE_W = 32
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator inputs
    input wire logic main_osc_pin,
    input wire logic ring_osc_clock,
    // clock outputs
    output logic main_osc_enable,
    output logic system_clock,
    output logic instruction_clock,
    output logic machine_cycle_pulse
);

    logic [scsd_pkg::MODE_W-1:0] clock_mode_select_reg;
    logic [2:0] main_sync_reg;
    logic [2:0] ring_sync_reg;
    logic applied_src_reg;
    logic [1:0] applied_div_reg;
    logic switching_reg;
    logic [2:0] pos_reg;
    logic [CYCLE_W-1:0] cycle_count;
    logic main_run;
    logic main_rise;
    logic ring_rise;
    logic src_level;
    logic src_rise;
    logic [2:0] pos_mask;
    logic boundary;
    logic main_stopped;
    logic src_change;
    logic sys_next;
    logic sys_rise;
    logic access;
    logic wr_take;
    logic addr_ok;

    // main oscillator runs only while its disable bit is clear
    assign main_run = !clock_mode_select_reg[scsd_pkg::OSC_DIS_BIT]; // see RL10

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_osc_enable <= 1'b0;
        else
            main_osc_enable <= main_run; // see RL10
    end

    // two-stage synchronisers plus one stage for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_sync_reg <= 3'h0;
            ring_sync_reg <= 3'h0;
        end
        else
        begin
            main_sync_reg <= {main_sync_reg[1:0], main_osc_pin}; // see RL9
            ring_sync_reg <= {ring_sync_reg[1:0], ring_osc_clock}; // see RL9
        end
    end

    assign main_rise = main_sync_reg[1] && !main_sync_reg[2] && main_run;
    assign ring_rise = ring_sync_reg[1] && !ring_sync_reg[2];

    // applied source; main only counts while its oscillator is enabled
    assign src_level = (applied_src_reg == scsd_pkg::SRC_RING) ? ring_sync_reg[1]
                     : (main_sync_reg[1] && main_run); // see RL1
    assign src_rise = (applied_src_reg == scsd_pkg::SRC_RING) ? ring_rise : main_rise;

    // mask of the position counter for the applied ratio
    always_comb
    begin
        case (applied_div_reg)
            2'h0: pos_mask = scsd_pkg::POS_MASK_1;
            2'h1: pos_mask = scsd_pkg::POS_MASK_2;
            2'h2: pos_mask = scsd_pkg::POS_MASK_4;
            default: pos_mask = scsd_pkg::POS_MASK_8;
        endcase
    end

    // a period ends on the rise that wraps the position; a stopped main
    // oscillator is left at once since it has no edges to wait for
    assign main_stopped = (applied_src_reg == scsd_pkg::SRC_MAIN) && !main_run; // see RL4
    assign src_change = clock_mode_select_reg[scsd_pkg::SRC_BIT] != applied_src_reg;
    assign boundary = (src_rise && ((pos_reg & pos_mask) == pos_mask))
                   || main_stopped; // see RL12

    // settings move to the divider only at a period boundary
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            applied_src_reg <= scsd_pkg::SRC_RING; // see RL7
            applied_div_reg <= scsd_pkg::DIV_8; // see RL7
            switching_reg <= 1'b0;
        end
        else if (boundary)
        begin
            // bit 1 is a don't-care for the ring source
            applied_src_reg <= clock_mode_select_reg[scsd_pkg::SRC_BIT]; // see RL1, RL3, RL4
            applied_div_reg <= clock_mode_select_reg[scsd_pkg::DIV_HI_BIT:
                                                     scsd_pkg::DIV_LO_BIT]; // see RL2, RL3
            // changing source waits for the new source's first rise, which is
            // itself a boundary and clears the flag
            switching_reg <= src_change || main_stopped; // see RL12
        end
    end

    // position of the source within the current output period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos_reg <= 3'h7; // first rise after reset opens a period
        else if (boundary)
            pos_reg <= (src_change || main_stopped) ? 3'h7 : 3'h0; // see RL12
        else if (src_rise)
            pos_reg <= (pos_reg + 3'h1) & pos_mask; // see RL2
    end

    // output is high for the first half of each divided period
    always_comb
    begin
        if (boundary)
            sys_next = !(src_change || main_stopped); // see RL12
        else if (switching_reg)
            sys_next = 1'b0; // see RL12
        else if (applied_div_reg == scsd_pkg::DIV_1)
            sys_next = src_level; // see RL2
        else if (src_rise)
            sys_next = ((pos_reg + 3'h1) & pos_mask) <= (pos_mask >> 1);
        else
            sys_next = system_clock;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            system_clock <= 1'b0;
        else
            system_clock <= sys_next;
    end

    assign sys_rise = sys_next && !system_clock;

    // instruction clock and machine cycle counting
    scsd_insn_div #(
        .CYCLE_W(CYCLE_W)
    ) u_insn_div (
        .pclk(pclk),
        .presetn(presetn),
        .sys_rise(sys_rise),
        .instruction_clock(instruction_clock),
        .machine_cycle_pulse(machine_cycle_pulse),
        .machine_cycle_count(cycle_count)
    );

    // apb: one wait state, answer registered
    assign access = psel && penable && !pready;
    assign wr_take = psel && penable && pready && pwrite;
    assign addr_ok = (paddr == scsd_pkg::ADDR_MODE) || (paddr == scsd_pkg::ADDR_STATUS)
                  || (paddr == scsd_pkg::ADDR_CYCLES);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access;
            pslverr <= access && (!addr_ok || (pwrite && paddr != scsd_pkg::ADDR_MODE));
        end
    end

    // mode register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_mode_select_reg <= scsd_pkg::MODE_RESET; // see RL7
        else if (wr_take && paddr == scsd_pkg::ADDR_MODE && !pslverr)
            clock_mode_select_reg <= pwdata[scsd_pkg::MODE_W-1:0];
    end

    // read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (access && !pwrite)
        begin
            if (paddr == scsd_pkg::ADDR_MODE)
                prdata <= {28'h0, clock_mode_select_reg};
            else if (paddr == scsd_pkg::ADDR_STATUS)
                prdata <= {27'h0, main_run, switching_reg, applied_src_reg, applied_div_reg};
            else if (paddr == scsd_pkg::ADDR_CYCLES)
                prdata <= 32'(cycle_count);
            else
                prdata <= 32'h0;
        end
        else if (!access)
            prdata <= 32'h0;
    end

endmodule : scsd_top

// file: rtl/scsd_pkg.sv
/*
 * Shared constants for the system clock select and divide block:
 * register map, field positions, reset values and divider settings.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package scsd_pkg;

    // register byte offsets
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CYCLES = 12'h008;

    // clock_mode_select fields
    localparam int MODE_W = 4;
    localparam int SRC_BIT = 0;
    localparam int OSC_DIS_BIT = 1;
    localparam int DIV_LO_BIT = 2;
    localparam int DIV_HI_BIT = 3;

    // ring oscillator divided by 8, main oscillator stopped
    localparam logic [3:0] MODE_RESET = 4'hf;

    // source encodings
    localparam logic SRC_MAIN = 1'b0;
    localparam logic SRC_RING = 1'b1;

    // divide codes: through, /2, /4, /8
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_8 = 2'h3;
    localparam logic [2:0] POS_MASK_1 = 3'h0;
    localparam logic [2:0] POS_MASK_2 = 3'h1;
    localparam logic [2:0] POS_MASK_4 = 3'h3;
    localparam logic [2:0] POS_MASK_8 = 3'h7;

    // instruction clock ratio
    localparam int INSN_DIV = 3;

    // status fields
    localparam int ST_DIV_LO = 0;
    localparam int ST_SRC = 2;
    localparam int ST_SWITCH = 3;
    localparam int ST_OSC_EN = 4;

endpackage : scsd_pkg

// file: rtl/scsd_insn_div.sv
/*
 * Divide-by-three instruction clock generator. Counts system clock
 * rising edges and marks each machine cycle.
 * Assumes sys_rise is a one-pclk pulse on each system clock rising edge.
 */
`timescale 1ns/100ps
module scsd_insn_div #(
    parameter int CYCLE_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // system clock edge
    input wire logic sys_rise,
    // instruction clock and machine cycles
    output logic instruction_clock,
    output logic machine_cycle_pulse,
    output logic [CYCLE_W-1:0] machine_cycle_count
);

    localparam logic [1:0] PHASE_LAST = 2'(scsd_pkg::INSN_DIV - 1);

    logic [1:0] phase_reg;

    // phase of the system clock within a machine cycle, known after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= 2'h0; // see RL13
        else if (sys_rise)
            phase_reg <= (phase_reg == PHASE_LAST) ? 2'h0 : phase_reg + 2'h1; // see RL5
    end

    // instruction clock high for the first system clock of each cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            instruction_clock <= 1'b0;
        else if (sys_rise)
            instruction_clock <= (phase_reg == PHASE_LAST); // see RL5
    end

    // one machine cycle per instruction clock period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            machine_cycle_pulse <= 1'b0;
            machine_cycle_count <= '0;
        end
        else
        begin
            machine_cycle_pulse <= sys_rise && (phase_reg == PHASE_LAST); // see RL6
            if (sys_rise && (phase_reg == PHASE_LAST))
                machine_cycle_count <= machine_cycle_count + CYCLE_W'(1); // see RL6
        end
    end

endmodule : scsd_insn_div

// file: sim/scsd_osc_model.sv
/* Oscillator sources for the clock select block.
   Assumes the block's main enable gates the main source. */
`timescale 1ns/100ps
module scsd_osc_model (
    // control from the block
    input wire logic main_osc_enable,
    // oscillator outputs
    output logic main_osc_pin,
    output logic ring_osc_clock
);
    // ring runs from power-up, 40 ns period
    initial
    begin
        ring_osc_clock = 1'b0;
        #1;
        forever #20 ring_osc_clock = ~ring_osc_clock;
    end
    // main 56 ns period while enabled, parked high when stopped
    initial
    begin
        main_osc_pin = 1'b1;
        forever #28 main_osc_pin = main_osc_enable ? ~main_osc_pin : 1'b1;
    end
endmodule : scsd_osc_model

// file: sim/scsd_top_sva.sv
/* Checker for scsd_top: clock shape, divide by three, reset state.
   Assumes it is bound to scsd_top, see the foot of this file. */
`timescale 1ns/100ps
module scsd_top_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // clock outputs
    input wire logic main_osc_enable,
    input wire logic system_clock,
    input wire logic instruction_clock,
    input wire logic machine_cycle_pulse
);
    logic sq_reg, iq_reg, seen_reg, en_reg;
    logic [3:0] rc_reg, pc_reg;
    wire ins_up = instruction_clock && !iq_reg;
    wire sys_up = system_clock && !sq_reg;
    wire wr_done = psel && penable && pready && pwrite && paddr == 12'h000;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // rises and pulses per instruction period
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            {sq_reg, iq_reg, seen_reg, en_reg} <= 4'h0;
            {rc_reg, pc_reg} <= 8'h00;
        end
        else
        begin
            {sq_reg, iq_reg} <= {system_clock, instruction_clock};
            seen_reg <= seen_reg | ins_up;
            rc_reg <= ins_up ? 4'(sys_up) : rc_reg + 4'(sys_up);
            pc_reg <= ins_up ? 4'(machine_cycle_pulse) : pc_reg + 4'(machine_cycle_pulse);
            if (wr_done)
                en_reg <= !pwdata[1];
        end
    // reset state, clock shape, ratios
    AST_RST_MAIN_OFF: assert property ($rose(presetn) |-> !main_osc_enable)
        else $error("main enabled after reset");
    AST_RST_PHASE: assert property ($rose(presetn) |-> !instruction_clock)
        else $error("instruction clock not at phase zero");
    AST_SYS_HIGH: assert property ($rose(system_clock) |=> system_clock)
        else $error("short high pulse");
    AST_SYS_LOW: assert property ($fell(system_clock) |=> !system_clock)
        else $error("short low pulse");
    AST_INSN_RATIO: assert property (ins_up && seen_reg |-> rc_reg == 4'h3)
        else $error("instruction period not three rises");
    AST_MC_ONE: assert property (ins_up && seen_reg |-> pc_reg == 4'h1)
        else $error("machine cycle count per period wrong");
    AST_MC_PULSE: assert property (machine_cycle_pulse |=> !machine_cycle_pulse)
        else $error("machine cycle pulse too long");
    AST_OSC_EN: assert property (wr_done |=> ##[0:1] main_osc_enable == en_reg)
        else $error("main enable does not follow mode");
endmodule : scsd_top_sva
bind scsd_top scsd_top_sva scsd_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .main_osc_enable(main_osc_enable), .system_clock(system_clock),
    .instruction_clock(instruction_clock), .machine_cycle_pulse(machine_cycle_pulse));

// file: sim/tb.sv
/* Bench for scsd_top: apb master, mode sweeps, period checks.
   Assumes the oscillator model drives both sources. */
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic er, pready, pslverr, main_osc_enable, system_clock, instruction_clock;
    logic machine_cycle_pulse, main_osc_pin, ring_osc_clock;
    int error_cnt = 0, checks_done = 0, d, hi;
    integer seed = 32'hfdf2;
    // 250 mhz clock
    always #2 pclk = ~pclk;
    scsd_top #(.CYCLE_W(32)) scsd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_osc_pin(main_osc_pin),
        .ring_osc_clock(ring_osc_clock), .main_osc_enable(main_osc_enable),
        .system_clock(system_clock), .instruction_clock(instruction_clock),
        .machine_cycle_pulse(machine_cycle_pulse));
    scsd_osc_model scsd_osc_model_inst (.main_osc_enable(main_osc_enable),
        .main_osc_pin(main_osc_pin), .ring_osc_clock(ring_osc_clock));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    function automatic int exp_per(input logic src, input logic [1:0] dv);
        return (src ? 10 : 14) << dv;
    endfunction : exp_per
    // set a mode, then time system and instruction clocks in pclk cycles
    task automatic run_mode(input logic [3:0] m, input logic wr);
        realtime t;
        int ps;
        if (wr)
            apb(1'b1, 12'h000, {28'($random(seed)), m});
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, {28'h0, m});
        repeat (3) @(posedge system_clock);
        t = $realtime;
        @(posedge system_clock);
        ps = int'(($realtime - t) / 4.0);
        chk(ps, exp_per(m[0], m[3:2]));
        @(posedge instruction_clock);
        t = $realtime;
        @(posedge instruction_clock);
        chk(int'(($realtime - t) / 4.0), 3 * ps);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[2:0], {m[0], m[3:2]});
        $display("mode %h done", m);
    endtask : run_mode
    // test sequence
    initial
    begin
        do_reset();
        chk(main_osc_enable, 1'b0);
        run_mode(4'hf, 1'b0);
        for (d = 0; d < 4; d++)
            run_mode({2'(d), 1'($random(seed)), 1'b1}, 1'b1);
        apb(1'b1, 12'h000, 32'hd);
        repeat (4) @(posedge pclk);
        chk(main_osc_enable, 1'b1);
        for (d = 0; d < 4; d++)
            run_mode({2'(d), 2'b00}, 1'b1);
        // stop main in the low half so no high pulse is cut short
        @(negedge system_clock);
        apb(1'b1, 12'h000, 32'h2);
        repeat (200) @(posedge pclk);
        hi = 0;
        repeat (300)
        begin
            @(posedge pclk);
            if (system_clock !== 1'b0)
                hi++;
        end
        chk(hi, 0);
        run_mode(4'hf, 1'b1);
        for (d = 0; d < 6; d++)
        begin
            apb(d[0] || d > 3, d < 4 ? {8'($random(seed)), 4'hc} : 12'(4 * d - 12), 32'h0);
            chk(rd, 32'h0);
            chk(32'(er), 32'h1);
        end
        run_mode(4'hf, 1'b0);
        $display("error test done");
        do_reset();
        run_mode(4'hf, 1'b0);
        // machine cycle counter advances once per instruction period
        @(posedge instruction_clock);
        apb(1'b0, 12'h008, 32'h0);
        hi = rd;
        repeat (2) @(posedge instruction_clock);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd - 32'(hi), 32'h2);
        $display("cycle count test done");
        give_verdict();
    end
    // hang guard, far above the expected run
    initial
    begin
        #240000;
        error_cnt++;
        $display("MISMATCH at %0t: timeout", $time);
        give_verdict();
    end
endmodule : tb
